// File: common/serial_port_config_pkg.sv
// Constants for the serial control port and its configuration register.
// Assumes a byte-wide register space reached over a 3-wire or 4-wire serial link.
package serial_port_config_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int INSTR_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [3:0] INSTR_LAST = 4'hf;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam int RW_BIT = 15;

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CONFIG_A_ADDR = 15'h0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
	localparam logic [BYTE_W-1:0] CONFIG_A_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] READ_ZERO = 8'h00;
	localparam int SOFT_RESET_BIT = 7;
	localparam int LSB_FIRST_BIT = 6;
	localparam int ADDR_ASCEND_BIT = 5;
	localparam int SDO_ACTIVE_BIT = 4;
	localparam int SDO_ACTIVE_MIRROR = 3;
	localparam int ADDR_ASCEND_MIRROR = 2;
	localparam int LSB_FIRST_MIRROR = 1;
	localparam int SOFT_RESET_MIRROR = 0;

	typedef enum logic {
		PH_INSTR,
		PH_DATA
	} phase_t;

endpackage

// File: src/pin_sync.sv
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin is quasi-static compared with clk; the first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and its synchronised copy
	input wire logic pin,
	input wire logic idle_level,
	output var logic synced
);
	logic meta_q;

	always_ff @(posedge clk) begin
		// Resetting to the pin's idle level keeps a false select or edge from following reset.
		if (!rst_n) begin
			meta_q <= idle_level;
			synced <= idle_level;
		end else begin
			meta_q <= pin;
			synced <= meta_q;
		end
	end

	cov_idle_a: cover property (@(posedge clk) disable iff (!rst_n) synced == idle_level);
endmodule // pin_sync
`default_nettype wire

// File: src/serial_port_config_reg.sv
// Serial control port slave holding the port configuration register.
// Assumes sclk, cs_n and sdio come from pins and are far slower than clk.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1: Writing bit 7 resets the device and starts a profile download when enabled.
// RULE2: Bit 6 picks bit order, one LSB first, zero MSB first.
// RULE3: Bit 5 set makes the address increment after each multibyte byte.
// RULE4: Bit 5 clear, the default, makes the address decrement after each byte.
// RULE5: Bit 4 set uses separate SDO; clear returns read data on the shared line.
// RULE6: Bits 3 to 0 mirror bits 7 to 4; effective value is their OR.
// RULE7: Mirror pairs are 3 with 4, 2 with 5, 1 with 6, 0 with 7.
// RULE8: The configuration register is never part of a saved EEPROM profile.
// RULE9: The soft reset bit clears itself once the reset has taken effect.
module serial_port_config_reg (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output var logic sdio_out,
	output var logic sdio_oe,
	output var logic sdo,
	output var logic sdo_oe,
	// Effective port settings
	output var logic lsb_first,
	output var logic addr_ascend,
	output var logic four_wire,
	// Device reset and profile download
	input wire logic profile_enable,
	output var logic soft_reset,
	output var logic profile_load,
	// Profile save read-out
	input wire logic save_rd,
	input wire logic [serial_port_config_pkg::ADDR_W-1:0] save_addr,
	output var logic [serial_port_config_pkg::BYTE_W-1:0] save_data,
	output var logic save_skip
);
	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic s_sclk;
	logic s_cs_n;
	logic s_sdio;
	logic sclk_prev_q;

	pin_sync u_sync_sclk (.clk(clk), .rst_n(rst_n), .pin(sclk), .idle_level(1'b0),
		.synced(s_sclk));
	pin_sync u_sync_cs (.clk(clk), .rst_n(rst_n), .pin(cs_n), .idle_level(1'b1),
		.synced(s_cs_n));
	pin_sync u_sync_sdio (.clk(clk), .rst_n(rst_n), .pin(sdio_in), .idle_level(1'b0),
		.synced(s_sdio));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= s_sclk;
		end
	end

	wire sel = ~s_cs_n;
	wire rise = sel & s_sclk & ~sclk_prev_q;
	wire fall = sel & ~s_sclk & sclk_prev_q;

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	serial_port_config_pkg::phase_t phase_q;
	logic [3:0] cnt_q;
	logic [serial_port_config_pkg::INSTR_W-1:0] instr_q;
	logic [serial_port_config_pkg::BYTE_W-1:0] rx_q;
	logic [serial_port_config_pkg::BYTE_W-1:0] tx_q;
	logic [serial_port_config_pkg::ADDR_W-1:0] addr_q;
	logic rw_q;
	logic [serial_port_config_pkg::BYTE_W-1:0] cfg_q;

	// Shift direction follows the effective bit order for both instruction and data.
	wire [serial_port_config_pkg::INSTR_W-1:0] instr_nx = lsb_first ?
		{s_sdio, instr_q[serial_port_config_pkg::INSTR_W-1:1]} :
		{instr_q[serial_port_config_pkg::INSTR_W-2:0], s_sdio}; // [RULE2]
	wire [serial_port_config_pkg::BYTE_W-1:0] rx_nx = lsb_first ?
		{s_sdio, rx_q[serial_port_config_pkg::BYTE_W-1:1]} :
		{rx_q[serial_port_config_pkg::BYTE_W-2:0], s_sdio}; // [RULE2]
	wire in_instr = phase_q == serial_port_config_pkg::PH_INSTR;
	wire instr_done = rise & in_instr & (cnt_q == serial_port_config_pkg::INSTR_LAST);
	wire byte_done = rise & ~in_instr & (cnt_q == serial_port_config_pkg::BYTE_LAST);
	wire hit = addr_q == serial_port_config_pkg::CONFIG_A_ADDR;
	wire [serial_port_config_pkg::BYTE_W-1:0] rdata =
		hit ? cfg_q : serial_port_config_pkg::READ_ZERO;
	wire [serial_port_config_pkg::ADDR_W-1:0] addr_nx = addr_ascend ?
		addr_q + serial_port_config_pkg::ADDR_STEP :
		addr_q - serial_port_config_pkg::ADDR_STEP; // [RULE3] [RULE4]
	wire rd_act = ~in_instr & rw_q;
	wire [serial_port_config_pkg::BYTE_W-1:0] tx_src =
		(cnt_q == serial_port_config_pkg::CNT_ZERO) ? rdata : tx_q;
	wire tx_bit = lsb_first ? tx_src[0] : tx_src[serial_port_config_pkg::BYTE_W-1]; // [RULE2]
	wire [serial_port_config_pkg::BYTE_W-1:0] tx_sh = lsb_first ?
		{1'b0, tx_src[serial_port_config_pkg::BYTE_W-1:1]} :
		{tx_src[serial_port_config_pkg::BYTE_W-2:0], 1'b0};
	wire wr_cfg = byte_done & ~rw_q & hit;
	// Either copy of the reset bit triggers it, so the pattern works in both bit orders.
	wire rst_req = wr_cfg & (rx_nx[serial_port_config_pkg::SOFT_RESET_BIT] |
		rx_nx[serial_port_config_pkg::SOFT_RESET_MIRROR]); // [RULE1] [RULE7]

	// ----------------------------------------------------------------
	// Frame sequencing
	// ----------------------------------------------------------------
	// Deselect aborts any partial byte; nothing half-received is ever applied.
	always_ff @(posedge clk) begin
		if (!rst_n || !sel) begin
			phase_q <= serial_port_config_pkg::PH_INSTR;
			cnt_q <= serial_port_config_pkg::CNT_ZERO;
		end else if (instr_done || byte_done) begin
			phase_q <= serial_port_config_pkg::PH_DATA;
			cnt_q <= serial_port_config_pkg::CNT_ZERO;
		end else if (rise) begin
			cnt_q <= cnt_q + serial_port_config_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			instr_q <= '0;
			rx_q <= '0;
			rw_q <= 1'b0;
			addr_q <= '0;
		end else begin
			if (rise && in_instr) instr_q <= instr_nx;
			if (rise && !in_instr) rx_q <= rx_nx;
			if (instr_done) begin
				rw_q <= instr_nx[serial_port_config_pkg::RW_BIT];
				addr_q <= instr_nx[serial_port_config_pkg::ADDR_W-1:0];
			end else if (byte_done) begin
				addr_q <= addr_nx; // [RULE3] [RULE4]
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data driver
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || !sel) begin
			tx_q <= '0;
			sdio_out <= 1'b0;
			sdo <= 1'b0;
			sdio_oe <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (fall && rd_act) begin
			tx_q <= tx_sh;
			sdio_out <= tx_bit;
			sdo <= tx_bit;
			sdio_oe <= ~four_wire; // [RULE5]
			sdo_oe <= four_wire; // [RULE5]
		end
	end

	// ----------------------------------------------------------------
	// Configuration register and soft reset
	// ----------------------------------------------------------------
	// A soft reset reloads the default byte, which also drops both reset bits.
	always_ff @(posedge clk) begin
		if (!rst_n || rst_req) begin
			cfg_q <= serial_port_config_pkg::CONFIG_A_RESET; // [RULE9]
		end else if (wr_cfg) begin
			cfg_q <= rx_nx;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_reset <= 1'b0;
			profile_load <= 1'b0;
			lsb_first <= 1'b0;
			addr_ascend <= 1'b0;
			four_wire <= 1'b0;
		end else begin
			soft_reset <= rst_req; // [RULE1]
			profile_load <= rst_req & profile_enable; // [RULE1]
			lsb_first <= cfg_q[serial_port_config_pkg::LSB_FIRST_BIT] |
				cfg_q[serial_port_config_pkg::LSB_FIRST_MIRROR]; // [RULE6] [RULE7]
			addr_ascend <= cfg_q[serial_port_config_pkg::ADDR_ASCEND_BIT] |
				cfg_q[serial_port_config_pkg::ADDR_ASCEND_MIRROR]; // [RULE6] [RULE7]
			four_wire <= cfg_q[serial_port_config_pkg::SDO_ACTIVE_BIT] |
				cfg_q[serial_port_config_pkg::SDO_ACTIVE_MIRROR]; // [RULE6] [RULE7]
		end
	end

	// ----------------------------------------------------------------
	// Profile save read-out
	// ----------------------------------------------------------------
	// Other blocks answer their own addresses; this one only vetoes the config byte.
	wire save_cfg = save_rd & (save_addr == serial_port_config_pkg::CONFIG_A_ADDR);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			save_data <= serial_port_config_pkg::READ_ZERO;
			save_skip <= 1'b0;
		end else begin
			save_data <= serial_port_config_pkg::READ_ZERO; // [RULE8]
			save_skip <= save_cfg; // [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	soft_rst_a: assert property (rst_req |=> soft_reset && cfg_q == '0) // [RULE1]
		else $error("soft reset not raised after reset write");
	load_req_a: assert property (soft_reset |-> profile_load == $past(profile_enable)) // [RULE1]
		else $error("profile download request wrong");
	first_bit_a: assert property (fall && rd_act && cnt_q == '0 |=> // [RULE2]
		sdio_out == ($past(lsb_first) ? $past(rdata[0]) : $past(rdata[7])))
		else $error("first read bit in wrong order");
	addr_inc_a: assert property (byte_done && addr_ascend |=> // [RULE3]
		addr_q == $past(addr_q) + serial_port_config_pkg::ADDR_STEP)
		else $error("address did not increment");
	addr_dec_a: assert property (byte_done && !addr_ascend |=> // [RULE4]
		addr_q == $past(addr_q) - serial_port_config_pkg::ADDR_STEP)
		else $error("address did not decrement");
	wire_mode_a: assert property ((sdio_oe |-> !four_wire) and (sdo_oe |-> four_wire)) // [RULE5]
		else $error("read data on the wrong line");
	mirror_or_a: assert property (wr_cfg && !rst_req |-> ##2 // [RULE6]
		four_wire == ($past(rx_nx[4], 2) | $past(rx_nx[3], 2)) &&
		lsb_first == ($past(rx_nx[6], 2) | $past(rx_nx[1], 2)))
		else $error("mirror bits not combined");
	mirror_rst_a: assert property (wr_cfg && rx_nx[0] |=> soft_reset) // [RULE7]
		else $error("bit 0 did not act as bit 7");
	save_excl_a: assert property (save_cfg |=> save_skip && save_data == '0) // [RULE8]
		else $error("config byte offered for saving");
	self_clr_a: assert property (soft_reset |-> !cfg_q[7] && !cfg_q[0] ##1 !soft_reset) // [RULE9]
		else $error("soft reset bit did not clear");

	cov_write_c: cover property (wr_cfg && !rst_req);
	cov_read4_c: cover property (byte_done && rw_q && four_wire);
	cov_rst_c: cover property (soft_reset && profile_load);
endmodule // serial_port_config_reg
`default_nettype wire

// File: test/spi_host.sv
// Serial host model that frames instructions and data bytes for the configuration port.
// Assumes clk is the 20 MHz system clock; sclk runs at 400 ns only inside frames.
`timescale 1ns/1ns
`default_nettype none
module spi_host (
	// Clock
	input wire logic clk,
	// Serial link
	output var logic sclk,
	output var logic cs_n,
	output wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic hd = 1'b0;
	logic hoe = 1'b1;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// A released shared line shows the inverse of the last bit so a held value cannot pass.
	assign sdio_in = sdio_oe ? sdio_out : (hoe ? hd : ~hd);
	task automatic sbit(input logic b, input logic four, output logic r);
		hd = b;
		repeat (4) @(negedge clk);
		sclk = 1'b1;
		repeat (4) @(negedge clk);
		// An undriven separate output shows its inverse so a missing enable cannot pass.
		r = four ? (sdo_oe ? sdo : ~sdo) : sdio_in;
		sclk = 1'b0;
	endtask
	task automatic xfer(input logic [15:0] ins, input logic [1:0][7:0] w, input int n,
		input logic lsb, input logic four, output logic [1:0][7:0] rd);
		logic r;
		cs_n = 1'b0;
		hoe = 1'b1;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 16; i++) sbit(ins[lsb ? i : 15 - i], four, r);
		hoe = !ins[15];
		for (int k = 0; k < n; k++) for (int i = 0; i < 8; i++) begin
			sbit(w[k][lsb ? i : 7 - i], four, r);
			rd[k][lsb ? i : 7 - i] = r;
		end
		cs_n = 1'b1;
		hoe = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule // spi_host
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the serial port configuration register.
// Assumes the host model in spi_host stands on the link side.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, rst_n, profile_enable, save_rd, cl, cf;
	logic [serial_port_config_pkg::ADDR_W-1:0] save_addr;
	wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo, sdo_oe;
	wire logic lsb_first, addr_ascend, four_wire, soft_reset, profile_load, save_skip;
	wire logic [serial_port_config_pkg::BYTE_W-1:0] save_data;
	wire logic [7:0] outs;
	logic [1:0][7:0] r;
	logic [7:0] e;
	logic [7:0] vals [7] = '{8'h10, 8'h08, 8'h20, 8'h04, 8'h40, 8'h02, 8'h00};
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_rst = 0;
	int n_load = 0;
	assign outs = {5'h00, lsb_first, addr_ascend, four_wire};
	serial_port_config_reg dut (.clk, .rst_n, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
		.sdo, .sdo_oe, .lsb_first, .addr_ascend, .four_wire, .profile_enable, .soft_reset,
		.profile_load, .save_rd, .save_addr, .save_data, .save_skip);
	spi_host host (.clk, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo, .sdo_oe);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Pulse counting and hang guard
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		n_rst <= n_rst + (soft_reset === 1'b1);
		n_load <= n_load + (profile_load === 1'b1);
		if (cyc == 20000) begin
			err_count = err_count + 1;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic xf(input logic rw, input logic [14:0] a, input logic [1:0][7:0] w, input int n);
		host.xfer({rw, a}, w, n, cl, cf, r);
	endtask
	// Expected effective settings as {lsb, ascend, four}; the mirror OR lets either half set them.
	function automatic logic [7:0] eff(input logic [7:0] v);
		return {5'h00, v[6] | v[1], v[5] | v[2], v[4] | v[3]};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, profile_enable, save_rd, cl, cf} = 5'h00;
		save_addr = 15'h0000;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk(outs, 8'h00);
		foreach (vals[i]) begin
			xf(1'b0, 15'h0000, {8'h00, vals[i]}, 1);
			e = eff(vals[i]);
			chk(outs, e);
			cl = e[2];
			cf = e[0];
			xf(1'b1, 15'h0000, 16'h0000, 1);
			chk(r[0], vals[i]);
		end
		// Writing from 0x0001 downward lands the second byte on the register.
		xf(1'b0, 15'h0001, {8'h18, 8'haa}, 2);
		cf = 1'b1;
		xf(1'b1, 15'h0001, 16'h0000, 2);
		chk(r[0], 8'h00);
		chk(r[1], 8'h18);
		xf(1'b0, 15'h0000, 16'h003c, 1);
		xf(1'b1, 15'h0001, 16'h0000, 2);
		chk(r[1], 8'h00);
		xf(1'b1, 15'h0000, 16'h0000, 1);
		chk(r[0], 8'h3c);
		for (int p = 0; p < 2; p++) begin
			profile_enable = p[0];
			n_rst = 0;
			n_load = 0;
			xf(1'b0, 15'h0000, p ? 16'h0081 : 16'h0001, 1);
			chk(8'(n_rst), 8'h01);
			chk(8'(n_load), 8'(p));
			cl = 1'b0;
			cf = 1'b0;
			chk(outs, 8'h00);
			xf(1'b1, 15'h0000, 16'h0000, 1);
			chk(r[0], 8'h00);
		end
		save_rd = 1'b1;
		for (int a = 0; a < 3; a++) begin
			save_addr = 15'(a % 2);
			@(negedge clk);
			chk({7'h00, save_skip}, 8'(a % 2 == 0));
			chk(save_data, 8'h00);
		end
		save_rd = 1'b0;
		results();
	end
endmodule // tb
`default_nettype wire
